// [pkg/acd_pkg.sv]
// Constants, codes and carrier types of the channel diagnostics block
package acd_pkg;
  localparam int NAIN = 4;
  localparam int NAOUT = 2;
  localparam int DW = 16;
  localparam int AW = 6;
  localparam int BUS_W = 32;

  // Register map, word addresses: group in [5:2], index in [1:0]
  localparam logic [3:0] G_SYS = 4'h0;
  localparam logic [3:0] G_AIN_CFG = 4'h4;
  localparam logic [3:0] G_AIN_OFF = 4'h5;
  localparam logic [3:0] G_AIN_VAL = 4'h6;
  localparam logic [3:0] G_AIN_DIAG = 4'h7;
  localparam logic [3:0] G_AO_CFG = 4'h8;
  localparam logic [3:0] G_AO_VAL = 4'h9;
  localparam logic [1:0] IX_CTRL = 2'h0;
  localparam logic [1:0] IX_STAT = 2'h1;
  localparam logic [1:0] IX_MASK = 2'h2;
  localparam logic [1:0] IX_SUM = 2'h3;
  localparam logic [1:0] AO_IDX_LIM = 2'h2;

  localparam int CTRL_IRQ_EN = 0;
  localparam int CTRL_APPLY = 1;
  localparam int STAT_W = 3;
  localparam int STAT_FAULT_ON = 0;
  localparam int STAT_FAULT_OFF = 1;
  localparam int STAT_PARAM_FIX = 2;

  // Input and output range codes; codes above the last are invalid
  localparam logic [2:0] AIN_R_OFF = 3'h0;
  localparam logic [2:0] AIN_R_020 = 3'h1;
  localparam logic [2:0] AIN_R_420 = 3'h2;
  localparam logic [2:0] AIN_R_V10 = 3'h3;
  localparam logic [2:0] AIN_R_MAX = 3'h3;
  localparam logic [1:0] AO_R_OFF = 2'h0;
  localparam logic [1:0] AO_R_V10 = 2'h1;
  localparam logic [1:0] AO_R_020 = 2'h2;
  localparam logic [1:0] AO_R_MAX = 2'h2;

  // Scale: 1 uA or 1 mV per count
  localparam logic signed [DW:0] WB_LIMIT = 17'sh00640;
  localparam logic signed [DW:0] I_OVF = 17'sh05be0;
  localparam logic signed [DW:0] I_UNF = 17'sh00000;
  localparam logic signed [DW:0] V_OVF = 17'sh02df0;
  localparam logic signed [DW:0] V_UNF = 17'sh1d210;
  localparam logic signed [DW:0] SAT_HI = 17'sh07fff;
  localparam logic signed [DW:0] SAT_LO = 17'sh18000;
  localparam logic [1:0] WB_COUNT = 2'h3;
  localparam logic [DW-1:0] FORCE_VAL = 16'h7fff;
  localparam logic [DW-1:0] ZERO_VAL = 16'h0000;

  typedef struct packed {
    logic wb_en;
    logic [2:0] range;
  } acd_ain_cfg_t;

  typedef struct packed {
    logic bad;
    logic wire_break;
    logic unf;
    logic ovf;
  } acd_ain_diag_t;

  typedef struct packed {
    logic valid;
    logic [DW-1:0] value;
  } acd_meas_t;

  localparam int AIN_CFG_W = 4;
  localparam int AO_CFG_W = 2;
  localparam acd_ain_cfg_t AIN_CFG_RST = 4'h0;
endpackage

// [test/acd_cpu.sv]
// Register bus master model standing in for the controlling CPU
`timescale 1ns/1ps
module acd_cpu (
  input wire logic clk,
  output logic [acd_pkg::AW-1:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [acd_pkg::BUS_W-1:0] avs_writedata,
  input wire logic [acd_pkg::BUS_W-1:0] avs_readdata,
  input wire logic avs_waitrequest
);
  import acd_pkg::*;
  initial begin
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
  end
  // One access, held until waitrequest is sampled low
  task automatic xfer(input logic w, input logic [AW-1:0] a,
      input logic [BUS_W-1:0] d, output logic [BUS_W-1:0] q);
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    do @(posedge clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Idle data inverted so stale data is never mistaken
    avs_writedata <= ~d;
  endtask
endmodule

// [test/tb.sv]
// Self-checking bench of the channel diagnostics top
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
  miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
  import acd_pkg::*;
  logic clk;
  logic rst_n;
  logic [AW-1:0] adr;
  logic rd;
  logic wr_s;
  logic [BUS_W-1:0] wd;
  logic [BUS_W-1:0] rdat;
  logic wait_s;
  acd_meas_t meas [NAIN];
  logic [DW-1:0] drv [NAOUT];
  logic fault;
  logic irq;
  int miscompares;
  int total_checks;
  logic [31:0] seed;
  logic [1:0] wbc;
  logic [3:0] flg;
  logic [1:0] ch;
  logic [17:0] e;
  int raw;
  int off;
  int wbs [7] = '{1599, 1599, 1600, 1599, 1599, 1599, 1600};
  int craw [10] = '{23519, 23520, 0, 100, 11759, 11760, -11760, -11761,
    -32768, 32767};
  int coff [10] = '{0, 0, 0, -101, 0, 0, 0, 0, -5, 5};
  // Bad output 1 gets a nonzero value so its zero drive is visible
  logic [5:0] ca [10] = '{6'h11, 6'h12, 6'h10, 6'h13, 6'h20, 6'h21,
    6'h24, 6'h25, 6'h02, 6'h00};
  logic [15:0] cd [10] = '{16'ha, 16'h4, 16'h9, 16'h3, 16'h1, 16'h3,
    16'h1234, 16'h5678, 16'h7, 16'h3};

  acd_top u_acd_top (.clk(clk), .rst_n(rst_n), .avs_address(adr),
    .avs_read(rd), .avs_write(wr_s), .avs_writedata(wd),
    .avs_readdata(rdat), .avs_waitrequest(wait_s), .meas_in(meas),
    .ao_drive(drv), .module_fault(fault), .irq(irq));
  acd_cpu u_acd_cpu (.clk(clk), .avs_address(adr), .avs_read(rd),
    .avs_write(wr_s), .avs_writedata(wd), .avs_readdata(rdat),
    .avs_waitrequest(wait_s));

  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  // Saturated corrected value with underflow and overflow above it
  function automatic logic [17:0] exp_meas(input logic volt, input int r,
      input int o);
    int c;
    logic [15:0] v;
    c = r + o;
    if (c > 32767) v = 16'h7fff;
    else if (c < -32768) v = 16'h8000;
    else v = c[15:0];
    if (volt) return {c < -11760, c >= 11760, v};
    return {c < 0, c >= 23520, v};
  endfunction

  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    u_acd_cpu.xfer(1'b1, a, d, q);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] x);
    logic [31:0] q;
    u_acd_cpu.xfer(1'b0, a, 32'h0, q);
    `CHK(q, x)
  endtask

  task automatic meas_one(input logic [1:0] i, input int r);
    @(posedge clk);
    meas[i] <= '{1'b1, r[15:0]};
    @(posedge clk);
    meas[i].valid <= 1'b0;
  endtask

  task automatic end_of_test();
    if (miscompares == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    #500000;
    miscompares++;
    end_of_test();
  end

  initial begin
    seed = 32'haaf0;
    miscompares = 0;
    total_checks = 0;
    wbc = 2'h0;
    flg = 4'h0;
    rst_n = 1'b0;
    foreach (meas[i]) meas[i] = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    `CHK(irq, 1'b0)
    `CHK(fault, 1'b0)
    rd_chk(6'h3f, 32'h0);
    rd_chk(6'h00, 32'h0);
    // Bad settings on inputs 1, 2 and output 1
    for (int k = 0; k < 10; k++) wr(ca[k], {16'h0, cd[k]});
    repeat (4) @(posedge clk);
    `CHK(drv[0], 16'h1234)
    `CHK(drv[1], 16'h0000)
    `CHK(fault, 1'b1)
    `CHK(irq, 1'b1)
    for (int i = 1; i < 3; i++) begin
      rd_chk({G_AIN_VAL, i[1:0]}, 32'h7fff);
      rd_chk({G_AIN_DIAG, i[1:0]}, 32'h8);
    end
    rd_chk(6'h03, 32'h9b);
    rd_chk(6'h01, 32'h1);
    wr(6'h01, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    // Corrected settings
    wr(6'h11, 32'h2);
    wr(6'h12, 32'h1);
    wr(6'h21, 32'h2);
    wr(6'h00, 32'h3);
    repeat (4) @(posedge clk);
    rd_chk(6'h1d, 32'h0);
    rd_chk(6'h01, 32'h6);
    `CHK(fault, 1'b0)
    `CHK(drv[1], 16'h5678)
    wr(6'h02, 32'h1);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    wr(6'h02, 32'h7);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b1)
    wr(6'h01, 32'h6);
    repeat (2) @(posedge clk);
    `CHK(irq, 1'b0)
    // Interrupts off: no status on bad and corrected settings
    for (int k = 0; k < 2; k++) begin
      wr(6'h12, k ? 32'h1 : 32'h5);
      wr(6'h00, 32'h2);
      repeat (4) @(posedge clk);
      rd_chk(6'h01, 32'h0);
      `CHK(fault, k == 0)
      `CHK(irq, 1'b0)
    end
    wr(6'h00, 32'h1);
    // Wire break debounce on input 0; wire break is diag bit 2
    foreach (wbs[k]) begin
      wbc = wbs[k] >= 1600 ? 2'h0 : (wbc == 2'h3 ? wbc : wbc + 2'h1);
      meas_one(2'h0, wbs[k]);
      rd_chk(6'h1c, {29'h0, wbc == 2'h3, 2'h0});
    end
    // Three back-to-back low readings, no gap between them
    @(posedge clk);
    meas[0] <= '{1'b1, 16'h063f};
    repeat (3) @(posedge clk);
    meas[0].valid <= 1'b0;
    rd_chk(6'h1c, 32'h4);
    meas_one(2'h0, 32'h640);
    rd_chk(6'h1c, 32'h0);
    // Corner and random readings on current input 1, voltage input 3
    for (int k = 0; k < 50; k++) begin
      ch = k < 4 ? 2'h1 : (k < 10 ? 2'h3 : (k[0] ? 2'h3 : 2'h1));
      raw = k < 10 ? craw[k] : int'(rnd() & 32'hffff) - 32768;
      off = k < 10 ? coff[k] : int'(rnd() & 32'h3fff) - 8192;
      wr({G_AIN_OFF, ch}, {16'h0, off[15:0]});
      meas_one(ch, raw);
      e = exp_meas(ch == 2'h3, raw, off);
      flg[ch] = |e[17:16];
      rd_chk({G_AIN_VAL, ch}, {16'h0, e[15:0]});
      rd_chk({G_AIN_DIAG, ch}, {30'h0, e[17:16]});
      `CHK(fault, |flg)
    end
    end_of_test();
  end
endmodule

// [verilog/acd_ain.sv]
// One analog input channel: correction, range, wire break, parameter check
`timescale 1ns/1ps
module acd_ain (
  input logic clk,
  input logic rst_n,
  input acd_pkg::acd_ain_cfg_t cfg,
  input logic [acd_pkg::DW-1:0] offset,
  input acd_pkg::acd_meas_t meas,
  output logic [acd_pkg::DW-1:0] value_q,
  output acd_pkg::acd_ain_diag_t diag_q
);
  import acd_pkg::*;
  logic signed [DW:0] corr, ovf_lim, unf_lim;
  logic bad, volt, active;
  logic [1:0] cnt_q, cnt_d;
  logic [DW-1:0] value_d;
  acd_ain_diag_t diag_d;

  always_comb begin
    corr = $signed({meas.value[DW-1], meas.value})
      + $signed({offset[DW-1], offset});
    bad = (cfg.range > AIN_R_MAX) || (cfg.wb_en && cfg.range != AIN_R_020);
    volt = cfg.range == AIN_R_V10;
    ovf_lim = volt ? V_OVF : I_OVF;
    unf_lim = volt ? V_UNF : I_UNF;
    active = !bad && cfg.range != AIN_R_OFF;
    cnt_d = cnt_q;
    value_d = value_q;
    diag_d = diag_q;
    diag_d.bad = bad;
    if (bad) begin
      value_d = FORCE_VAL;
      diag_d.ovf = 1'b0;
      diag_d.unf = 1'b0;
      diag_d.wire_break = 1'b0;
      cnt_d = 2'h0;
    end else if (!active) begin
      value_d = ZERO_VAL;
      diag_d.ovf = 1'b0;
      diag_d.unf = 1'b0;
      diag_d.wire_break = 1'b0;
      cnt_d = 2'h0;
    end else if (meas.valid) begin
      if (corr > SAT_HI) value_d = SAT_HI[DW-1:0];
      else if (corr < SAT_LO) value_d = SAT_LO[DW-1:0];
      else value_d = corr[DW-1:0];
      diag_d.ovf = corr >= ovf_lim;
      diag_d.unf = corr < unf_lim;
      if (cfg.wb_en && corr < WB_LIMIT) begin
        if (cnt_q != WB_COUNT) cnt_d = cnt_q + 2'h1;
      end else begin
        cnt_d = 2'h0;
      end
      diag_d.wire_break = cnt_d == WB_COUNT;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= 2'h0;
      value_q <= ZERO_VAL;
      diag_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      value_q <= value_d;
      diag_q <= diag_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wb_report: assert property (
    diag_q.wire_break |-> cnt_q == WB_COUNT)
    else $error("wire break reported before count of three");
  a_wb_clear: assert property (
    meas.valid && active && corr >= WB_LIMIT |=> !diag_q.wire_break
    && cnt_q == 2'h0)
    else $error("good reading did not clear wire break");
  a_wb_three: assert property (
    (meas.valid && active && cfg.wb_en && corr < WB_LIMIT)[*3]
    |-> ##1 diag_q.wire_break)
    else $error("three low readings gave no wire break");
  a_ovf_level: assert property (
    meas.valid && active |=> diag_q.ovf == ($past(corr) >= $past(ovf_lim)))
    else $error("overflow bit does not follow corrected value");
  a_force_val: assert property (
    diag_q.bad |-> value_q == FORCE_VAL)
    else $error("bad channel value not forced");
endmodule

// [verilog/acd_aout.sv]
// One analog output channel: parameter check and safe zero drive
`timescale 1ns/1ps
module acd_aout (
  input logic clk,
  input logic rst_n,
  input logic [acd_pkg::AO_CFG_W-1:0] cfg,
  input logic [acd_pkg::DW-1:0] value,
  output logic [acd_pkg::DW-1:0] drive_q,
  output logic bad_q
);
  import acd_pkg::*;
  logic bad_d;
  logic [DW-1:0] drive_d;

  always_comb begin
    bad_d = cfg > AO_R_MAX;
    drive_d = (bad_d || cfg == AO_R_OFF) ? ZERO_VAL : value;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      bad_q <= 1'b0;
      drive_q <= ZERO_VAL;
    end else begin
      bad_q <= bad_d;
      drive_q <= drive_d;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_out_zero: assert property (
    bad_q |-> drive_q == ZERO_VAL)
    else $error("bad output channel not driven to zero");
  a_out_check: assert property (
    cfg > AO_R_MAX |=> bad_q)
    else $error("invalid output range not flagged");
endmodule

// [verilog/acd_top.sv]
// Channel diagnostics top: register slave, channels, fault and interrupt
`timescale 1ns/1ps
module acd_top (
  input logic clk,
  input logic rst_n,
  input logic [acd_pkg::AW-1:0] avs_address,
  input logic avs_read,
  input logic avs_write,
  input logic [acd_pkg::BUS_W-1:0] avs_writedata,
  output logic [acd_pkg::BUS_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  input acd_pkg::acd_meas_t meas_in [acd_pkg::NAIN],
  output logic [acd_pkg::DW-1:0] ao_drive [acd_pkg::NAOUT],
  output logic module_fault,
  output logic irq
);
  import acd_pkg::*;

  logic req, take;
  logic [3:0] grp;
  logic [1:0] idx;
  logic [BUS_W-1:0] rd_mux;

  logic wait_q, wait_d;
  logic [BUS_W-1:0] rdata_q, rdata_d;
  logic irq_en_q, irq_en_d;
  logic apply;
  logic [STAT_W-1:0] stat_q, stat_d, mask_q, mask_d, clr, ev;
  logic irq_q, irq_d;
  logic fault, fault_q, bad_any, bad_q;

  acd_ain_cfg_t cfg_s_q [NAIN];
  acd_ain_cfg_t cfg_s_d [NAIN];
  acd_ain_cfg_t cfg_a_q [NAIN];
  acd_ain_cfg_t cfg_a_d [NAIN];
  logic [DW-1:0] off_q [NAIN];
  logic [DW-1:0] off_d [NAIN];
  logic [AO_CFG_W-1:0] aocfg_s_q [NAOUT];
  logic [AO_CFG_W-1:0] aocfg_s_d [NAOUT];
  logic [AO_CFG_W-1:0] aocfg_a_q [NAOUT];
  logic [AO_CFG_W-1:0] aocfg_a_d [NAOUT];
  logic [DW-1:0] aoval_q [NAOUT];
  logic [DW-1:0] aoval_d [NAOUT];

  logic [DW-1:0] ain_val [NAIN];
  acd_ain_diag_t ain_diag [NAIN];
  logic [NAIN-1:0] ain_flt, ain_bad;
  logic [NAOUT-1:0] ao_bad;

  genvar g;
  generate
    for (g = 0; g < NAIN; g++) begin : g_ain
      acd_ain u_ain (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(cfg_a_q[g]),
        .offset(off_q[g]),
        .meas(meas_in[g]),
        .value_q(ain_val[g]),
        .diag_q(ain_diag[g])
      );
      assign ain_flt[g] = |ain_diag[g];
      assign ain_bad[g] = ain_diag[g].bad;
    end
    for (g = 0; g < NAOUT; g++) begin : g_aout
      acd_aout u_aout (
        .clk(clk),
        .rst_n(rst_n),
        .cfg(aocfg_a_q[g]),
        .value(aoval_q[g]),
        .drive_q(ao_drive[g]),
        .bad_q(ao_bad[g])
      );
    end
  endgenerate

  // Bus decode; one wait cycle per access keeps read data registered
  always_comb begin
    req = avs_read || avs_write;
    take = req && !wait_q;
    grp = avs_address[AW-1:2];
    idx = avs_address[1:0];
  end

  always_comb begin
    rd_mux = '0;
    case (grp)
      G_SYS: begin
        case (idx)
          IX_CTRL: rd_mux = BUS_W'(irq_en_q);
          IX_STAT: rd_mux = BUS_W'(stat_q);
          IX_MASK: rd_mux = BUS_W'(mask_q);
          IX_SUM: rd_mux = BUS_W'({ao_bad, ain_flt, bad_q, fault_q});
          default: rd_mux = '0;
        endcase
      end
      G_AIN_CFG: rd_mux = BUS_W'(cfg_s_q[idx]);
      G_AIN_OFF: rd_mux = BUS_W'(off_q[idx]);
      G_AIN_VAL: rd_mux = BUS_W'(ain_val[idx]);
      G_AIN_DIAG: rd_mux = BUS_W'(ain_diag[idx]);
      G_AO_CFG: begin
        if (idx < AO_IDX_LIM) rd_mux = BUS_W'(aocfg_s_q[idx[0]]);
      end
      G_AO_VAL: begin
        if (idx < AO_IDX_LIM) rd_mux = BUS_W'(aoval_q[idx[0]]);
      end
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    wait_d = 1'b1;
    rdata_d = rdata_q;
    if (req && wait_q) begin
      wait_d = 1'b0;
      rdata_d = avs_read ? rd_mux : '0;
    end
    irq_en_d = irq_en_q;
    mask_d = mask_q;
    clr = '0;
    apply = 1'b0;
    cfg_s_d = cfg_s_q;
    cfg_a_d = cfg_a_q;
    off_d = off_q;
    aocfg_s_d = aocfg_s_q;
    aocfg_a_d = aocfg_a_q;
    aoval_d = aoval_q;
    if (take && avs_write) begin
      case (grp)
        G_SYS: begin
          case (idx)
            IX_CTRL: begin
              irq_en_d = avs_writedata[CTRL_IRQ_EN];
              apply = avs_writedata[CTRL_APPLY];
            end
            IX_STAT: clr = avs_writedata[STAT_W-1:0];
            IX_MASK: mask_d = avs_writedata[STAT_W-1:0];
            default: ;
          endcase
        end
        G_AIN_CFG: cfg_s_d[idx] = avs_writedata[AIN_CFG_W-1:0];
        G_AIN_OFF: off_d[idx] = avs_writedata[DW-1:0];
        G_AO_CFG: begin
          if (idx < AO_IDX_LIM) begin
            aocfg_s_d[idx[0]] = avs_writedata[AO_CFG_W-1:0];
          end
        end
        G_AO_VAL: begin
          if (idx < AO_IDX_LIM) aoval_d[idx[0]] = avs_writedata[DW-1:0];
        end
        default: ;
      endcase
    end
    // staged set becomes active, channels recheck
    if (apply) begin
      cfg_a_d = cfg_s_d;
      aocfg_a_d = aocfg_s_d;
    end
  end

  always_comb begin
    fault = |ain_flt || |ao_bad;
    bad_any = |ain_bad || |ao_bad;
    ev = '0;
    ev[STAT_FAULT_ON] = fault && !fault_q;
    ev[STAT_FAULT_OFF] = !fault && fault_q;
    ev[STAT_PARAM_FIX] = !bad_any && bad_q;
    // events only with interrupts enabled; set beats clear
    stat_d = (stat_q & ~clr) | (irq_en_q ? ev : '0);
    irq_d = |(stat_d & mask_q);
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wait_q <= 1'b1;
      rdata_q <= '0;
      irq_en_q <= 1'b0;
      stat_q <= '0;
      mask_q <= '0;
      irq_q <= 1'b0;
      fault_q <= 1'b0;
      bad_q <= 1'b0;
      cfg_s_q <= '{default: AIN_CFG_RST};
      cfg_a_q <= '{default: AIN_CFG_RST};
      off_q <= '{default: ZERO_VAL};
      aocfg_s_q <= '{default: AO_R_OFF};
      aocfg_a_q <= '{default: AO_R_OFF};
      aoval_q <= '{default: ZERO_VAL};
    end else begin
      wait_q <= wait_d;
      rdata_q <= rdata_d;
      irq_en_q <= irq_en_d;
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      fault_q <= fault;
      bad_q <= bad_any;
      cfg_s_q <= cfg_s_d;
      cfg_a_q <= cfg_a_d;
      off_q <= off_d;
      aocfg_s_q <= aocfg_s_d;
      aocfg_a_q <= aocfg_a_d;
      aoval_q <= aoval_d;
    end
  end

  always_comb begin
    avs_readdata = rdata_q;
    avs_waitrequest = wait_q;
    module_fault = fault_q;
    irq = irq_q;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_bus_answer: assert property (
    req && avs_waitrequest |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus answer not after exactly one wait cycle");
  a_fault_or: assert property (
    module_fault == $past(fault))
    else $error("module fault does not follow diagnostic bits");
  a_fault_irq: assert property (
    $rose(fault_q) && $past(irq_en_q) && $past(mask_q[STAT_FAULT_ON])
    |-> irq_q && stat_q[STAT_FAULT_ON])
    else $error("fault rise gave no interrupt");
  a_fix_gate: assert property (
    $fell(bad_q) && !$past(irq_en_q) && !$past(stat_q[STAT_PARAM_FIX])
    |-> !stat_q[STAT_PARAM_FIX])
    else $error("correction flagged with interrupts disabled");
  a_fix_event: assert property (
    $fell(bad_q) && $past(irq_en_q) |-> stat_q[STAT_PARAM_FIX])
    else $error("parameter correction not flagged");
endmodule
